// file: asr_pkg.sv
// Package with timing and encoding constants for the static memory host controller
package asr_pkg;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 4;
  localparam int CLK_PERIOD_NS = 8;
  // Timing figures in ns, fastest speed grade
  localparam int ACCESS_NS = 25;
  localparam int OE_ACCESS_NS = 15;
  localparam int WZ_NS = 15;
  localparam int WP_NS = 20;
  localparam int FAST_WP_NS = 13;
  localparam int DSETUP_NS = 13;
  localparam int FAST_DSETUP_NS = 18;
  localparam int FAST_WC_NS = 18;
  localparam int HZ_NS = 15;
  localparam int AHOLD_NS = 5;
  // Cycle counts: all times round up; access adds one more cycle
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int WZ_CYC = (WZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FAST_WP_CYC = (FAST_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HZ_CYC = (HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (AHOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  // Write styles
  localparam logic [1:0] WR_STROBE = 2'h0;
  localparam logic [1:0] WR_SELECT = 2'h1;
  localparam logic [1:0] WR_FAST = 2'h2;
  typedef enum logic [2:0] {
    ASR_IDLE   = 3'b000,
    ASR_RD     = 3'b001,
    ASR_WR_HIZ = 3'b010,
    ASR_WR_DRV = 3'b011,
    ASR_WR_END = 3'b100,
    ASR_RECOV  = 3'b101
  } asr_state_e;
endpackage

// file: asr_host.sv
// Host controller that drives a 16K by 4 asynchronous static memory over its pins
//
// Function
// - Read only while write strobe high, select and output enable low.
// - Host drives write data only after delay, or keeps output enable high.
// - Strobe-terminated write ends at strobe rise; data held across it.
// - Select-terminated write ends at select rise; outputs stay high impedance.
// - Fast write keeps output enable high, select low; outputs never turn on.
// - Fast write pulse counts from the 18 ns figure but rounds to the same 3 cycles as other writes.
`timescale 1ns/1ns
`default_nettype none
module asr_host #(
  parameter int ADDR_W = asr_pkg::ADDR_W,
  parameter int DATA_W = asr_pkg::DATA_W
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [1:0]        req_style,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic                   chip_select_n,
  output logic                   output_drive_enable_n,
  output logic                   write_strobe_n,
  output logic [ADDR_W-1:0]      word_select_lines,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe,
  input  wire logic [DATA_W-1:0] data_in
);

  asr_pkg::asr_state_e state_r;
  logic [asr_pkg::CNT_W-1:0] cnt_r;
  logic                      wr_r;
  logic [1:0]                style_r;
  logic [DATA_W-1:0]         wdata_r;
  logic                      take;

  // A request is taken only while the registered ready stands high
  assign take = req_valid && req_ready;

  // Ready comes from a flop; a take drops it at once so no second request slips in
  always_ff @(posedge clk) begin
    if (rst) begin
      req_ready <= 1'b0;
    end else if (take) begin
      req_ready <= 1'b0;
    end else if (state_r == asr_pkg::ASR_IDLE) begin
      req_ready <= 1'b1;
    end else if (state_r == asr_pkg::ASR_RECOV && cnt_r == '0) begin
      req_ready <= 1'b1;
    end else begin
      req_ready <= 1'b0;
    end
  end

  // Sequencer
  // Each counting state lasts its load value plus one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= asr_pkg::ASR_IDLE;
      cnt_r   <= '0;
      wr_r    <= 1'b0;
      style_r <= asr_pkg::WR_STROBE;
      wdata_r <= '0;
    end else begin
      case (state_r)
        asr_pkg::ASR_IDLE: begin
          if (take) begin
            wr_r    <= req_write;
            style_r <= req_style;
            wdata_r <= req_wdata;
            if (req_write) begin
              state_r <= asr_pkg::ASR_WR_HIZ;
              cnt_r   <= asr_pkg::CNT_W'(asr_pkg::WZ_CYC);
            end else begin
              state_r <= asr_pkg::ASR_RD;
              cnt_r   <= asr_pkg::CNT_W'(asr_pkg::ACCESS_CYC);
            end
          end
        end
        asr_pkg::ASR_RD: begin
          if (cnt_r == '0) begin
            state_r <= asr_pkg::ASR_RECOV;
            cnt_r   <= asr_pkg::CNT_W'(asr_pkg::HZ_CYC);
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        asr_pkg::ASR_WR_HIZ: begin
          if (cnt_r == '0) begin
            state_r <= asr_pkg::ASR_WR_DRV;
            cnt_r   <= (style_r == asr_pkg::WR_FAST) ?
                       asr_pkg::CNT_W'(asr_pkg::FAST_WP_CYC) :
                       asr_pkg::CNT_W'(asr_pkg::WP_CYC);
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        asr_pkg::ASR_WR_DRV: begin
          if (cnt_r == '0) begin
            state_r <= asr_pkg::ASR_WR_END;
            cnt_r   <= asr_pkg::CNT_W'(asr_pkg::HOLD_CYC);
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        asr_pkg::ASR_WR_END: begin
          if (cnt_r == '0) begin
            state_r <= asr_pkg::ASR_RECOV;
            cnt_r   <= asr_pkg::CNT_W'(asr_pkg::HZ_CYC);
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        asr_pkg::ASR_RECOV: begin
          if (cnt_r == '0) begin
            state_r <= asr_pkg::ASR_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: begin
          state_r <= asr_pkg::ASR_IDLE;
        end
      endcase
    end
  end

  // Control pins
  always_ff @(posedge clk) begin
    if (rst) begin
      chip_select_n         <= 1'b1;
      output_drive_enable_n <= 1'b1;
      write_strobe_n        <= 1'b1;
      word_select_lines     <= '0;
    end else begin
      case (state_r)
        asr_pkg::ASR_IDLE: begin
          if (take) begin
            word_select_lines     <= req_addr;
            chip_select_n         <= 1'b0;
            // Strobe falls with select, so memory outputs stay off
            write_strobe_n        <= !req_write;
            output_drive_enable_n <= req_write;
          end
        end
        asr_pkg::ASR_WR_DRV: begin
          if (cnt_r == '0) begin
            if (style_r == asr_pkg::WR_SELECT) begin
              chip_select_n <= 1'b1;
            end else begin
              write_strobe_n <= 1'b1;
            end
          end
        end
        asr_pkg::ASR_WR_END: begin
          if (cnt_r == '0) begin
            chip_select_n  <= 1'b1;
            write_strobe_n <= 1'b1;
          end
        end
        asr_pkg::ASR_RD: begin
          if (cnt_r == '0) begin
            chip_select_n         <= 1'b1;
            output_drive_enable_n <= 1'b1;
          end
        end
        default: begin
          chip_select_n         <= chip_select_n;
          output_drive_enable_n <= output_drive_enable_n;
        end
      endcase
    end
  end

  // Data bus drive, held through strobe or select rise
  always_ff @(posedge clk) begin
    if (rst) begin
      data_out <= '0;
      data_oe  <= 1'b0;
    end else if (state_r == asr_pkg::ASR_WR_HIZ && cnt_r == '0) begin
      data_out <= wdata_r;
      data_oe  <= 1'b1;
    end else if (state_r == asr_pkg::ASR_WR_END && cnt_r == '0) begin
      data_oe <= 1'b0;
    end
  end

  // Read capture, plus a response pulse at the end of each write
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (state_r == asr_pkg::ASR_RD && cnt_r == '0) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= data_in;
      end else if (state_r == asr_pkg::ASR_WR_END && cnt_r == '0 && wr_r) begin
        rsp_valid <= 1'b1;
      end
    end
  end

endmodule // asr_host
`default_nettype wire

// file: asr_host_chk.sv
// Checker of pin sequencing for the static memory host
`timescale 1ns/1ns
`default_nettype none
module asr_host_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic chip_select_n,
  input wire logic output_drive_enable_n,
  input wire logic write_strobe_n,
  input wire logic data_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  idle_pins_a: assert property (req_ready |-> chip_select_n && write_strobe_n && !data_oe)
    else $error("pins not idle");
  read_only_a: assert property (!output_drive_enable_n |-> write_strobe_n && !chip_select_n)
    else $error("read enable outside read");
  no_fight_a: assert property (!output_drive_enable_n |-> !data_oe)
    else $error("host drives during read");
  fast_off_a: assert property (!write_strobe_n |-> output_drive_enable_n)
    else $error("enable low in write");
  strobe_sel_a: assert property ($fell(write_strobe_n) |-> $fell(chip_select_n))
    else $error("strobe fell alone");
  data_wait_a: assert property ($fell(write_strobe_n) |-> (!data_oe)[*2])
    else $error("data driven too early");
  data_hold_a: assert property (($rose(write_strobe_n) && !chip_select_n) ||
    ($rose(chip_select_n) && !write_strobe_n) |-> data_oe)
    else $error("data not held at end");
  read_len_a: assert property ($fell(output_drive_enable_n) |-> (!output_drive_enable_n)[*5])
    else $error("read too short");
  read_rsp_a: assert property ($rose(output_drive_enable_n) |-> rsp_valid)
    else $error("read without answer");
  c_read: cover property ($rose(output_drive_enable_n));
  c_wr_sel: cover property ($rose(chip_select_n) && !write_strobe_n);
  c_wr_stb: cover property ($rose(write_strobe_n) && !chip_select_n);
endmodule // asr_host_chk
bind asr_host asr_host_chk asr_host_chk_i (.clk, .rst, .req_ready, .rsp_valid,
  .chip_select_n, .output_drive_enable_n, .write_strobe_n, .data_oe);
`default_nettype wire

// file: asr_mem_model.sv
// Behavioural model of the 16K by 4 static memory
`timescale 1ns/1ns
`default_nettype none
module asr_mem_model (
  input  wire logic        cs_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [13:0] addr,
  input  wire logic [3:0]  din,
  input  wire logic        din_oe,
  output logic [3:0]       dq
);
  logic [3:0] mem [16384];
  logic [3:0] last = 4'h0;
  wire rd = !cs_n && !oe_n && we_n;
  wire act = !cs_n && !we_n;
  // Write lands when the first of strobe or select rises
  always @(negedge act) if (din_oe) mem[addr] = din;
  always @(negedge rd) last = mem[addr];
  // Released pins show the inverse of the last word
  assign dq = rd ? mem[addr] : ~last;
endmodule // asr_mem_model
`default_nettype wire

// file: async_sram_16k_by_4_port_tb_top.sv
// Self-checking bench for the static memory host controller
`timescale 1ns/1ns
`default_nettype none
module async_sram_16k_by_4_port_tb_top;
  logic clk = 0, rst = 1, req_valid = 0, req_write = 0;
  logic [1:0] req_style = 2'h0;
  logic [13:0] req_addr = 14'h0000;
  logic [3:0] req_wdata = 4'h0;
  wire logic req_ready, rsp_valid, cs_n, oe_n, we_n, data_oe;
  wire logic [13:0] wsl;
  wire logic [3:0] rsp_rdata, data_out, data_in;
  int n_errors = 0, checks = 0;
  always #4 clk = ~clk;
  asr_host asr_host_i (.clk, .rst, .req_valid, .req_write, .req_style, .req_addr,
    .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .chip_select_n(cs_n),
    .output_drive_enable_n(oe_n), .write_strobe_n(we_n), .word_select_lines(wsl),
    .data_out, .data_oe, .data_in);
  asr_mem_model asr_mem_model_i (.cs_n, .oe_n, .we_n, .addr(wsl), .din(data_out),
    .din_oe(data_oe), .dq(data_in));
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_hi(input bit rsp);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      if ((rsp ? rsp_valid : req_ready) === 1'b1) return;
    end
    n_errors++;
    results();
  endtask
  task automatic op(input logic w, input logic [1:0] s, input logic [13:0] a,
                    input logic [3:0] d);
    wait_hi(1'b0);
    @(posedge clk);
    {req_valid, req_write, req_style, req_addr, req_wdata} <= {1'b1, w, s, a, d};
    @(posedge clk);
    req_valid <= 1'b0;
    wait_hi(1'b1);
    if (!w) check(rsp_rdata, d);
  endtask
  task automatic t_styles;
    for (int s = 0; s < 3; s++) op(1'b1, s[1:0], 14'h0010 + s[13:0], 4'ha ^ s[3:0]);
    for (int s = 0; s < 3; s++) op(1'b0, 2'h0, 14'h0010 + s[13:0], 4'ha ^ s[3:0]);
  endtask
  task automatic t_edges;
    op(1'b1, 2'h2, 14'h0000, 4'h3);
    op(1'b1, 2'h0, 14'h3fff, 4'he);
    op(1'b0, 2'h0, 14'h0000, 4'h3);
    op(1'b0, 2'h0, 14'h3fff, 4'he);
    check({2'h0, data_oe, cs_n}, 4'h1);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_styles();
    t_edges();
    results();
  end
endmodule // async_sram_16k_by_4_port_tb_top
`default_nettype wire
